// File: inc/pecint_defs.svh
`ifndef PECINT_DEFS_SVH
`define PECINT_DEFS_SVH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define PECINT_ADDR_RISE 8'h00
`define PECINT_ADDR_FALL 8'h04
`define PECINT_ADDR_FLAGS 8'h08
`define PECINT_ADDR_CTRL 8'h0C
`define PECINT_ADDR_STAT 8'h10
`define PECINT_ADDR_MASK 8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define PECINT_CTRL_SUMMARY 0
`define PECINT_CTRL_MASTER 3
`define PECINT_STAT_EDGE 0
`define PECINT_STAT_WAKE 1

// ****************************************************************
// reset values
// ****************************************************************
`define PECINT_RST_EN 8'h00
`define PECINT_RST_FLAGS 8'h00
`define PECINT_RST_EVT 2'h0

`endif

// File: inc/pecint_pkg.sv
package pecint_pkg;

    typedef enum logic [1:0] {
        PECINT_BUS_IDLE,
        PECINT_BUS_ACK,
        PECINT_BUS_GAP
    } pecint_bus_t;

    typedef logic [7:0] pecint_byte_t;

endpackage

// File: hdl/pecint_sync.sv
`timescale 1ns/1ps

module pecint_sync #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = ce ? d : meta_ff;
        nxt_sync = ce ? meta_ff : sync_ff;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign q = sync_ff;
endmodule

// File: hdl/pecint_edge.sv
`timescale 1ns/1ps

module pecint_edge #(
    parameter int WIDTH = 8
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] level,
    input wire logic [WIDTH-1:0] rise_en,
    input wire logic [WIDTH-1:0] fall_en,
    output logic [WIDTH-1:0] hit
);
    logic [WIDTH-1:0] prev_ff;
    logic [WIDTH-1:0] nxt_prev;

    always_comb
    begin
        nxt_prev = ce ? level : prev_ff;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prev_ff <= '0;
        end
        else
        begin
            prev_ff <= nxt_prev;
        end
    end

    // per-pin detectors, either or both directions
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++)
        begin : g_pin
            assign hit[g] = ce & ((rise_en[g] & level[g] & ~prev_ff[g]) |
                (fall_en[g] & ~level[g] & prev_ff[g]));
        end
    endgenerate
endmodule

// File: hdl/pecint_top.sv
// Added by the designer: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "pecint_defs.svh"

module pecint_top #(
    parameter int WIDTH = 8
) (
    input wire logic REF_CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [WIDTH-1:0] PORT_PIN,
    input wire logic SLEEP,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic CHANGE_IRQ,
    output logic WAKE,
    output logic IRQ
);
    // ************************************************************
    // state
    // ************************************************************
    logic [WIDTH-1:0] pin_sync;
    logic [WIDTH-1:0] hit;
    logic [WIDTH-1:0] rise_ff, nxt_rise;
    logic [WIDTH-1:0] fall_ff, nxt_fall;
    logic [WIDTH-1:0] flags_ff, nxt_flags;
    logic master_ff, nxt_master;
    logic [1:0] evt_ff, nxt_evt;
    logic [1:0] mask_ff, nxt_mask;
    logic [31:0] dat_ff, nxt_dat;
    logic chg_irq_ff, nxt_chg_irq;
    logic wake_ff, nxt_wake;
    logic irq_ff, nxt_irq;
    pecint_pkg::pecint_bus_t bus_ff, nxt_bus;
    logic ack_ff, nxt_ack;
    logic acc;
    logic wr;
    logic summary;

    pecint_sync #(.WIDTH(WIDTH)) u_sync (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .ce(CE),
        .d(PORT_PIN),
        .q(pin_sync)
    );

    pecint_edge #(.WIDTH(WIDTH)) u_edge (
        .clk(REF_CLK),
        .rst_b(RST_B),
        .ce(CE),
        .level(pin_sync),
        .rise_en(rise_ff),
        .fall_en(fall_ff),
        .hit(hit)
    );

    function automatic logic is_addr(input logic [7:0] a,
        input logic [7:0] r);
        is_addr = (a == r);
    endfunction

    assign acc = CE & WB_CYC_I & WB_STB_I &
        (bus_ff == pecint_pkg::PECINT_BUS_IDLE);
    // writes land on the edge at which the master sees ack
    assign wr = CE & WB_CYC_I & WB_STB_I & WB_WE_I & WB_SEL_I[0] &
        (bus_ff == pecint_pkg::PECINT_BUS_ACK);
    assign summary = |flags_ff;

    // ************************************************************
    // bus handshake
    // ************************************************************
    always_comb
    begin
        nxt_bus = bus_ff;
        if (CE)
        begin
            unique case (bus_ff)
                pecint_pkg::PECINT_BUS_IDLE:
                    if (acc)
                        nxt_bus = pecint_pkg::PECINT_BUS_ACK;
                pecint_pkg::PECINT_BUS_ACK:
                    nxt_bus = pecint_pkg::PECINT_BUS_GAP;
                pecint_pkg::PECINT_BUS_GAP:
                    if (!(WB_CYC_I & WB_STB_I))
                        nxt_bus = pecint_pkg::PECINT_BUS_IDLE;
                default:
                    nxt_bus = pecint_pkg::PECINT_BUS_IDLE;
            endcase
        end
        // ack kept in a flop of its own, one cycle after the take
        nxt_ack = (nxt_bus == pecint_pkg::PECINT_BUS_ACK);
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            bus_ff <= pecint_pkg::PECINT_BUS_IDLE;
            ack_ff <= 1'b0;
        end
        else
        begin
            bus_ff <= nxt_bus;
            ack_ff <= nxt_ack;
        end
    end

    // ************************************************************
    // registers and flags
    // ************************************************************
    always_comb
    begin
        nxt_rise = rise_ff;
        nxt_fall = fall_ff;
        nxt_flags = flags_ff;
        nxt_master = master_ff;
        nxt_mask = mask_ff;
        nxt_evt = evt_ff;
        nxt_dat = dat_ff;
        if (CE)
        begin
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_RISE))
                nxt_rise = WB_DAT_I[WIDTH-1:0];
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_FALL))
                nxt_fall = WB_DAT_I[WIDTH-1:0];
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_FLAGS))
                nxt_flags = WB_DAT_I[WIDTH-1:0];
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_CTRL))
                nxt_master = WB_DAT_I[`PECINT_CTRL_MASTER];
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_MASK))
                nxt_mask = WB_DAT_I[1:0];
            if (wr && is_addr(WB_ADR_I, `PECINT_ADDR_STAT))
                nxt_evt = evt_ff & ~WB_DAT_I[1:0];
            // hardware set wins over any write
            nxt_flags = nxt_flags | hit;
            if (|hit)
                nxt_evt[`PECINT_STAT_EDGE] = 1'b1;
            if ((|hit) && SLEEP && master_ff)
                nxt_evt[`PECINT_STAT_WAKE] = 1'b1;
            nxt_dat = 32'h0;
            if (acc && !WB_WE_I)
            begin
                if (is_addr(WB_ADR_I, `PECINT_ADDR_RISE))
                    nxt_dat[WIDTH-1:0] = rise_ff;
                else if (is_addr(WB_ADR_I, `PECINT_ADDR_FALL))
                    nxt_dat[WIDTH-1:0] = fall_ff;
                else if (is_addr(WB_ADR_I, `PECINT_ADDR_FLAGS))
                    nxt_dat[WIDTH-1:0] = flags_ff;
                else if (is_addr(WB_ADR_I, `PECINT_ADDR_CTRL))
                begin
                    nxt_dat[`PECINT_CTRL_MASTER] = master_ff;
                    nxt_dat[`PECINT_CTRL_SUMMARY] = summary;
                end
                else if (is_addr(WB_ADR_I, `PECINT_ADDR_STAT))
                    nxt_dat[1:0] = evt_ff;
                else if (is_addr(WB_ADR_I, `PECINT_ADDR_MASK))
                    nxt_dat[1:0] = mask_ff;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb
    begin
        nxt_chg_irq = chg_irq_ff;
        nxt_wake = wake_ff;
        nxt_irq = irq_ff;
        if (CE)
        begin
            nxt_chg_irq = master_ff & summary;
            nxt_wake = SLEEP & master_ff & (|hit);
            nxt_irq = |(evt_ff & mask_ff);
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rise_ff <= `PECINT_RST_EN;
            fall_ff <= `PECINT_RST_EN;
            flags_ff <= `PECINT_RST_FLAGS;
            master_ff <= 1'b0;
            mask_ff <= 2'h0;
            evt_ff <= `PECINT_RST_EVT;
            dat_ff <= 32'h0;
        end
        else
        begin
            rise_ff <= nxt_rise;
            fall_ff <= nxt_fall;
            flags_ff <= nxt_flags;
            master_ff <= nxt_master;
            mask_ff <= nxt_mask;
            evt_ff <= nxt_evt;
            dat_ff <= nxt_dat;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            chg_irq_ff <= 1'b0;
            wake_ff <= 1'b0;
            irq_ff <= 1'b0;
        end
        else
        begin
            chg_irq_ff <= nxt_chg_irq;
            wake_ff <= nxt_wake;
            irq_ff <= nxt_irq;
        end
    end

    assign WB_DAT_O = dat_ff;
    assign WB_ACK_O = ack_ff;
    assign CHANGE_IRQ = chg_irq_ff;
    assign WAKE = wake_ff;
    assign IRQ = irq_ff;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!RST_B);

    flag_set_a: assert property (CE && hit[0] |=> flags_ff[0])
        else $error("flag not set by edge");
    set_wins_a: assert property (CE && wr && hit[1] |=> flags_ff[1])
        else $error("write lost an edge");
    no_arm_a: assert property (!rise_ff[2] && !fall_ff[2]
        |-> !hit[2])
        else $error("unarmed pin detected");
    rise_only_a: assert property (!fall_ff[3] && hit[3]
        |-> pin_sync[3])
        else $error("falling edge without enable");
    master_off_a: assert property (CE && hit[0] && !master_ff
        |=> flags_ff[0] ##1 !CHANGE_IRQ)
        else $error("request without master");
    summary_a: assert property (CE && master_ff && $stable(master_ff)
        |=> CHANGE_IRQ == |$past(flags_ff))
        else $error("summary mismatch");
    clear_flag_a: assert property (wr && is_addr(WB_ADR_I, 8'h08)
        && !WB_DAT_I[4] && !hit[4] |=> !flags_ff[4])
        else $error("flag not cleared");
    wake_edge_a: assert property (CE && SLEEP && master_ff && |hit
        |=> WAKE && (flags_ff != 8'h00))
        else $error("no wake on edge");
    edge_det_a: assert property (CE && rise_ff[5] && pin_sync[5]
        && !$past(pin_sync[5]) && $past(CE) |-> hit[5])
        else $error("edge missed");
    ack_one_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held");
    ack_take_a: assert property (acc |=> WB_ACK_O)
        else $error("no ack after take");
    fall_only_a: assert property (!rise_ff[6] && hit[6]
        |-> !pin_sync[6])
        else $error("rising edge without enable");
    flag_hold_a: assert property (!wr && flags_ff[7]
        |=> flags_ff[7])
        else $error("flag lost without write");
    wake_master_a: assert property (CE && !master_ff |=> !WAKE)
        else $error("wake without master");
    summary_rd_a: assert property (acc && !WB_WE_I
        && is_addr(WB_ADR_I, `PECINT_ADDR_CTRL)
        |=> WB_DAT_O[`PECINT_CTRL_SUMMARY] == |$past(flags_ff))
        else $error("summary bit misread");
    ce_hold_a: assert property (!CE |=> $stable(flags_ff)
        && $stable(rise_ff) && $stable(evt_ff) && $stable(WB_ACK_O))
        else $error("state moved with clock enable low");
    irq_level_a: assert property (CE
        |=> IRQ == |($past(evt_ff) & $past(mask_ff)))
        else $error("irq level wrong");
    evt_set_a: assert property (CE && |hit |=> evt_ff[0])
        else $error("edge event lost");

    flag_cov_c: cover property (hit[0] ##1 flags_ff[0]);
    race_cov_c: cover property (wr && |hit);
    wake_cov_c: cover property (WAKE);
    irq_cov_c: cover property (IRQ);
    wr_cov_c: cover property (WB_ACK_O && WB_WE_I);
endmodule

// File: bench/pecint_pins.sv
`timescale 1ns/1ps

module pecint_pins (
    input wire logic clk,
    input wire logic [7:0] lvl,
    output logic [7:0] pins
);
    // levels change just after an edge and hold many cycles
    always @(posedge clk)
        pins <= lvl;
endmodule

// File: bench/test_port_edge_change_interrupt.sv
`timescale 1ns/1ps
`include "pecint_defs.svh"

module test_port_edge_change_interrupt;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic sleep = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic [3:0] wsel = 4'hF;
    logic [7:0] lvl = 8'h00;
    logic [7:0] pins;
    logic [31:0] dat_o;
    logic ack;
    logic chg_irq;
    logic wake;
    logic irq;
    int n_fail = 0;
    int samples_checked = 0;
    int n;
    logic [31:0] exp_q[$];
    logic [15:0] seed = 16'h3054;
    logic [7:0] rise_en;
    logic [7:0] fall_en;

    always #5 clk = ~clk;

    pecint_pins u_pins (.clk(clk), .lvl(lvl), .pins(pins));

    pecint_top u_dut (
        .REF_CLK(clk), .RST_B(rst_b), .CE(ce), .PORT_PIN(pins),
        .SLEEP(sleep), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .CHANGE_IRQ(chg_irq),
        .WAKE(wake), .IRQ(irq)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= wsel;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        if (k >= 50)
            chk("ack", 1, 0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        wb(1'b0, a, 32'h0);
    endtask

    task automatic pin(input logic [7:0] v);
        @(posedge clk);
        lvl <= v;
        repeat (8) @(posedge clk);
    endtask

    always @(posedge clk)
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0 && exp_q.size() != 0)
            chk("read data", exp_q.pop_front(), dat_o);

    task automatic end_sim;
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        end_sim();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        rd(`PECINT_ADDR_RISE, 32'h0);
        rd(`PECINT_ADDR_FALL, 32'h0);
        rd(`PECINT_ADDR_FLAGS, 32'h0);
        wb(1'b1, 8'h20, 32'hFF);
        rd(8'h20, 32'h0);
        repeat (4)
        begin
            seed = lfsr(seed);
            rise_en = seed[7:0];
            seed = lfsr(seed);
            fall_en = seed[15:8];
            wb(1'b1, `PECINT_ADDR_RISE, {24'h0, rise_en});
            wb(1'b1, `PECINT_ADDR_FALL, {24'h0, fall_en});
            wb(1'b1, `PECINT_ADDR_CTRL, 32'h0);
            pin(8'hFF);
            rd(`PECINT_ADDR_FLAGS, {24'h0, rise_en});
            chk("change irq", 0, chg_irq);
            rd(`PECINT_ADDR_CTRL, {31'h0, |rise_en});
            wb(1'b1, `PECINT_ADDR_FLAGS, 32'h0);
            rd(`PECINT_ADDR_FLAGS, 32'h0);
            pin(8'h00);
            rd(`PECINT_ADDR_FLAGS, {24'h0, fall_en});
            wb(1'b1, `PECINT_ADDR_CTRL, 32'h8);
            repeat (2) @(posedge clk);
            chk("change irq", {31'h0, |fall_en}, chg_irq);
            rd(`PECINT_ADDR_CTRL, {28'h0, 1'b1, 2'h0, |fall_en});
            wb(1'b1, `PECINT_ADDR_FLAGS, 32'h0);
        end
        wb(1'b1, `PECINT_ADDR_RISE, 32'hFF);
        wb(1'b1, `PECINT_ADDR_FALL, 32'h0);
        @(posedge clk);
        sleep <= 1'b1;
        lvl <= 8'h01;
        n = 0;
        while (wake !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("wake", 1, wake);
        sleep <= 1'b0;
        rd(`PECINT_ADDR_FLAGS, 32'h1);
        rd(`PECINT_ADDR_STAT, 32'h3);
        chk("irq", 0, irq);
        wb(1'b1, `PECINT_ADDR_MASK, 32'h1);
        repeat (2) @(posedge clk);
        chk("irq", 1, irq);
        wb(1'b1, `PECINT_ADDR_STAT, 32'h3);
        repeat (2) @(posedge clk);
        chk("irq", 0, irq);
        rd(`PECINT_ADDR_STAT, 32'h0);
        // edge lands on the same edge as a flag write
        @(posedge clk);
        lvl <= 8'h03;
        @(posedge clk);
        wb(1'b1, `PECINT_ADDR_FLAGS, 32'h0);
        rd(`PECINT_ADDR_FLAGS, 32'h2);
        // write with byte lane 0 off is dropped
        wsel = 4'hE;
        wb(1'b1, `PECINT_ADDR_RISE, 32'h0);
        wsel = 4'hF;
        rd(`PECINT_ADDR_RISE, 32'hFF);
        // short pulse while clock enable is low is not seen
        @(posedge clk);
        ce <= 1'b0;
        lvl <= 8'h07;
        repeat (4) @(posedge clk);
        lvl <= 8'h03;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        rd(`PECINT_ADDR_FLAGS, 32'h2);
        // second reset in mid-run
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(`PECINT_ADDR_FLAGS, 32'h0);
        rd(`PECINT_ADDR_FALL, 32'h0);
        rd(`PECINT_ADDR_CTRL, 32'h0);
        end_sim();
    end
endmodule
